// file: design/ucsdec_pkg.sv
// Package for the alpha-field decoder: coding forms, markers, widths and states.
package ucsdec_pkg;
    // ==========================================================
    // Octet markers
    localparam logic [7:0] FORM_PAIRS = 8'h80; // Plain 16-bit pairs
    localparam logic [7:0] FORM_HALF = 8'h81;  // Count, half-page base
    localparam logic [7:0] FORM_FULL = 8'h82;  // Count, full 16-bit base
    localparam logic [7:0] FILLER = 8'hFF;     // Unused octet
    // ==========================================================
    // Buffer shape and reset values
    localparam int BUF_DEPTH = 2;              // Entries of the output buffer
    localparam int BUF_WIDTH = 17;             // Tag bit plus 16 data bits
    localparam logic [15:0] BASE_RESET = 16'h0000;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    // ==========================================================
    // Decoder states
    typedef enum logic [2:0] {
        UCSDEC_LEAD,   // Waiting for the leading octet
        UCSDEC_COUNT,  // Character count octet
        UCSDEC_BASEH,  // Base pointer high byte
        UCSDEC_BASEL,  // Base pointer low byte (full form only)
        UCSDEC_HIGH,   // Pair form: high byte expected
        UCSDEC_LOW,    // Pair form: low byte expected
        UCSDEC_BODY,   // Counted forms: character octets
        UCSDEC_SKIP    // Drain rest of record
    } ucsdec_state_t;
endpackage : ucsdec_pkg

// file: design/ucsdec_buf.sv
// Two-entry valid/ready buffer holding decoded characters.
`timescale 1ns/1ps
module ucsdec_buf (
    input wire logic clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [ucsdec_pkg::BUF_WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [ucsdec_pkg::BUF_WIDTH-1:0] out_data
);
    import ucsdec_pkg::*;
    // ==========================================================
    // Storage
    logic [BUF_WIDTH-1:0] mem [BUF_DEPTH]; // Entries, read from a register
    logic rd_ptr;                          // Oldest entry
    logic wr_ptr;                          // Next free entry
    logic [1:0] fill;                      // Number of held entries
    logic push;
    logic pop;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = (fill != 2'h2);      // Honest full, reaches the decoder
    // Write side
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
    // Pointers and fill count
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            fill <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            fill <= fill + {1'b0, push} - {1'b0, pop};
        end
    end
    // Registered read data: head entry loaded only on a pop or a push into an empty buffer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            // Next head depends on what is pushed and popped this cycle
            if (pop) begin
                if (fill == 2'h2) begin
                    out_valid <= 1'b1;
                    out_data <= mem[~rd_ptr];
                end else if (push) begin
                    out_valid <= 1'b1;
                    out_data <= in_data;
                end else begin
                    out_valid <= 1'b0;
                end
            end else if (!out_valid && push) begin
                out_valid <= 1'b1;
                out_data <= in_data;
            end
        end
    end
endmodule : ucsdec_buf

// file: design/ucsdec_top.sv
// Alpha-field decoder: octets of one record in, tagged characters out.
// How it works
// - 0x80: octet pairs give high_byte then low_byte
// - 0x80: stop at FFFF pair or filler
// - 0x81: second octet counts emitted characters
// - 0x81: base is third octet shifted seven
// - 0x81: top bit clear is default alphabet
// - 0x82: count then two-octet base pointer
// - 0x82: top bit set adds offset
// - Form chosen once per record
// - All three forms supported for any set
// - FF inside count is a real character
`timescale 1ns/1ps
module ucsdec_top (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic OCT_VALID,
    output logic OCT_READY,
    input wire logic [7:0] OCT_DATA,
    input wire logic OCT_LAST,
    output logic CHR_VALID,
    input wire logic CHR_READY,
    output logic CHR_UCS2,
    output logic [15:0] CHR_CODE,
    output logic BUSY
);
    import ucsdec_pkg::*;
    // ==========================================================
    // Decoder state
    ucsdec_state_t state;         // Position within the record
    logic [7:0] count;            // Characters still to emit
    logic [15:0] base;            // Base pointer, half-page or full 16-bit
    logic [7:0] high_byte;        // First octet of a pair
    logic emit;                   // Character offered to buffer
    logic [BUF_WIDTH-1:0] chr;    // Tag and code offered
    logic buf_ready;              // Buffer can take a character
    logic take;                   // Octet accepted this cycle
    logic [BUF_WIDTH-1:0] buf_data;
    logic buf_valid;
    logic plain_emit;             // Pass-through character offered
    logic [7:0] plain_oct;        // Pass-through octet held for one cycle
    logic buf_in_valid;           // Character pushed toward the buffer
    logic buf_push;               // Buffer accepts a character
    logic buf_pop;                // Receiver takes a character
    logic room_next;              // At most one entry held after this edge
    // Octets are only taken while OCT_READY is high, so the card never loses one
    assign take = OCT_VALID && OCT_READY;
    assign buf_in_valid = emit || plain_emit;
    assign buf_push = buf_in_valid && buf_ready;
    assign buf_pop = buf_valid && CHR_READY;
    // Full next cycle if full and not drained, or one held and one more arriving
    assign room_next = !((!buf_ready && !buf_pop) ||
                         (buf_valid && buf_ready && buf_push && !buf_pop));
    // ==========================================================
    // Character builder for counted forms
    function automatic logic [BUF_WIDTH-1:0] counted_char(input logic [7:0] oct,
                                                          input logic [15:0] b);
        if (oct[7]) begin
            counted_char = {1'b1, b + {9'h000, oct[6:0]}};
        end else begin
            counted_char = {1'b0, 9'h000, oct[6:0]};
        end
    endfunction : counted_char
    // ==========================================================
    // Main sequencer; the leading octet fixes the form for the record
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state <= UCSDEC_LEAD;
            count <= COUNT_RESET;
            base <= BASE_RESET;
            high_byte <= 8'h00;
            emit <= 1'b0;
            chr <= '0;
        end else begin
            emit <= 1'b0;
            if (take) begin
                case (state)
                    UCSDEC_LEAD: begin
                        if (OCT_DATA == FORM_PAIRS) begin
                            state <= UCSDEC_HIGH;
                        end else if (OCT_DATA == FORM_HALF || OCT_DATA == FORM_FULL) begin
                            state <= UCSDEC_COUNT;
                            base <= {15'h0000, OCT_DATA[1]};          // Remembers form
                        end else begin
                            // Default-alphabet record: octets pass through
                            emit <= 1'b1;
                            chr <= {1'b0, 8'h00, OCT_DATA};
                            state <= UCSDEC_SKIP;
                        end
                    end
                    UCSDEC_COUNT: begin
                        count <= OCT_DATA;
                        state <= UCSDEC_BASEH;
                    end
                    UCSDEC_BASEH: begin
                        if (base[0]) begin
                            base <= {OCT_DATA, 8'h00};
                            state <= UCSDEC_BASEL;
                        end else begin
                            base <= {1'b0, OCT_DATA, 7'h00};
                            state <= (count == 8'h00) ? UCSDEC_SKIP : UCSDEC_BODY;
                        end
                    end
                    UCSDEC_BASEL: begin
                        base <= {base[15:8], OCT_DATA};
                        state <= (count == 8'h00) ? UCSDEC_SKIP : UCSDEC_BODY;
                    end
                    UCSDEC_BODY: begin
                        // Every octet within the count is a character
                        emit <= 1'b1;
                        chr <= counted_char(OCT_DATA, base);
                        count <= count - 8'h01;
                        if (count == 8'h01) begin
                            state <= UCSDEC_SKIP;                     // Rest is filler
                        end
                    end
                    UCSDEC_HIGH: begin
                        if (OCT_DATA == FILLER && OCT_LAST) begin
                            state <= UCSDEC_SKIP;
                        end else begin
                            high_byte <= OCT_DATA;
                            state <= UCSDEC_LOW;
                        end
                    end
                    UCSDEC_LOW: begin
                        if (high_byte == FILLER && OCT_DATA == FILLER) begin
                            state <= UCSDEC_SKIP;
                        end else begin
                            emit <= 1'b1;
                            chr <= {1'b1, high_byte, OCT_DATA};
                            state <= UCSDEC_HIGH;
                        end
                    end
                    UCSDEC_SKIP: begin
                        // Plain octets leave through the pass-through stage; forms drain
                    end
                    default: begin
                        state <= UCSDEC_LEAD;
                    end
                endcase
                if (OCT_LAST) begin
                    state <= UCSDEC_LEAD;                             // Record ends
                end
            end
        end
    end
    // ==========================================================
    // Default-alphabet pass-through flag, set when a record has no marker
    logic plain;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            plain <= 1'b0;
        end else if (take) begin
            if (OCT_LAST) begin
                plain <= 1'b0;
            end else if (state == UCSDEC_LEAD) begin
                plain <= (OCT_DATA != FORM_PAIRS) && (OCT_DATA != FORM_HALF) &&
                         (OCT_DATA != FORM_FULL);
            end
        end
    end
    // Plain records emit from a separate stage so SKIP stays simple
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            plain_emit <= 1'b0;
            plain_oct <= 8'h00;
        end else begin
            plain_emit <= take && plain && (state == UCSDEC_SKIP);
            plain_oct <= OCT_DATA;
        end
    end
    // ==========================================================
    // Output buffer; a stalled receiver back-pressures the octet stream
    ucsdec_buf u_buf (
        .clk(CLK),
        .resetn(RESETN),
        .in_valid(buf_in_valid),
        .in_ready(buf_ready),
        .in_data(plain_emit ? {1'b0, 8'h00, plain_oct} : chr),
        .out_valid(buf_valid),
        .out_ready(CHR_READY),
        .out_data(buf_data)
    );
    // Output register stage: ports come from flip-flops
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            OCT_READY <= 1'b0;
            BUSY <= 1'b0;
        end else begin
            // Never ready right after a take: the character it makes is still on
            // its way, so the buffer slot is kept for it; this halves the octet rate
            OCT_READY <= !take && room_next;
            BUSY <= (state != UCSDEC_LEAD);
        end
    end
    assign CHR_VALID = buf_valid;
    assign CHR_UCS2 = buf_data[BUF_WIDTH-1];
    assign CHR_CODE = buf_data[15:0];
    // ==========================================================
    // Checks
    a_pair_order: assert property (@(posedge CLK) disable iff (!RESETN)
        (take && state == UCSDEC_LOW && !OCT_LAST && !(high_byte == FILLER && OCT_DATA == FILLER))
        |=> (emit && chr == {1'b1, $past(high_byte), $past(OCT_DATA)}))
        else $error("pair not emitted high then low");
    a_filler_stop: assert property (@(posedge CLK) disable iff (!RESETN)
        (take && state == UCSDEC_LOW && high_byte == FILLER && OCT_DATA == FILLER)
        |=> !emit)
        else $error("filler pair emitted");
    a_count_load: assert property (@(posedge CLK) disable iff (!RESETN)
        (take && state == UCSDEC_COUNT && !OCT_LAST) |=> count == $past(OCT_DATA))
        else $error("count not loaded");
    a_half_base: assert property (@(posedge CLK) disable iff (!RESETN)
        (take && state == UCSDEC_BASEH && !base[0])
        |=> base == {1'b0, $past(OCT_DATA), 7'h00})
        else $error("half base malformed");
    a_full_base: assert property (@(posedge CLK) disable iff (!RESETN)
        (take && state == UCSDEC_BASEL) |=> base[7:0] == $past(OCT_DATA))
        else $error("full base low byte wrong");
    a_body_char: assert property (@(posedge CLK) disable iff (!RESETN)
        (take && state == UCSDEC_BODY) |=> emit && chr[BUF_WIDTH-1] == $past(OCT_DATA[7]))
        else $error("body octet mis-tagged");
    a_body_count: assert property (@(posedge CLK) disable iff (!RESETN)
        (take && state == UCSDEC_BODY && !OCT_LAST) |=> count == $past(count) - 8'h01)
        else $error("count not decremented");
    a_skip_quiet: assert property (@(posedge CLK) disable iff (!RESETN)
        (take && state == UCSDEC_SKIP && !plain) |=> !emit && !plain_emit)
        else $error("character after end of counted form");
    a_buf_room: assert property (@(posedge CLK) disable iff (!RESETN)
        buf_in_valid |-> buf_ready)
        else $error("character pushed into a full buffer");
endmodule : ucsdec_top

// file: testbench/ucsdec_card_model.sv
// Card storage model: offers the octets of one record on a valid/ready handshake.
`timescale 1ns/1ps
module ucsdec_card_model (
    input wire logic clk,
    input wire logic oct_ready,
    output logic oct_valid,
    output logic [7:0] oct_data,
    output logic oct_last,
    output logic timed_out
);
    integer seed = 98; // Gap pattern seed
    // ==========================================================
    // Idle: data shows the inverse of the last octet, so stale data never matches
    initial begin
        oct_valid = 1'b0;
        oct_data = 8'h00;
        oct_last = 1'b0;
        timed_out = 1'b0;
    end
    // ==========================================================
    // Sender: whole record, last octet flagged, request held until taken
    task automatic send(input logic [7:0] rec[$], input bit slow);
        int wait_n;
        for (int i = 0; i < rec.size(); i++) begin
            oct_valid = 1'b1;
            oct_data = rec[i];
            oct_last = (i == rec.size() - 1);
            wait_n = 0;
            do begin
                @(posedge clk);
                wait_n++;
            end while (oct_ready !== 1'b1 && wait_n < 300);
            if (wait_n >= 300)
                timed_out = 1'b1;
            @(negedge clk);
            // Gaps only between octets, never inside a held request
            if ((slow && $random(seed) % 2 == 0) || i == rec.size() - 1) begin
                oct_valid = 1'b0;
                oct_data = ~rec[i];
                oct_last = 1'b0;
                @(negedge clk);
            end
        end
    endtask : send
endmodule : ucsdec_card_model

// file: testbench/ucsdec_top_test.sv
// Self-checking bench for the alpha-field decoder: corner records plus random ones.
`timescale 1ns/1ps
module ucsdec_top_test;
    import ucsdec_pkg::*;
    logic clk = 1'b0; // 100 MHz
    logic resetn = 1'b0; // Active-low reset
    logic chr_ready = 1'b0; // Receiver acceptance
    logic oct_valid, oct_last, oct_ready, chr_valid, chr_ucs2, busy, timed_out;
    logic [7:0] oct_data;
    logic [15:0] chr_code;
    logic [16:0] exp_q[$]; // Characters due, tag bit on top
    logic [7:0] rec[$]; // Record being built
    integer seed = 98;
    int miscompares = 0;
    int tests_run = 0;
    bit ready_rand = 1'b0; // Random receiver stalls
    bit ready_hold = 1'b0; // Long receiver stall
    initial begin
        forever #5 clk = ~clk;
    end
    // Receiver side, changed at the falling edge
    always @(negedge clk)
        chr_ready <= !ready_hold && (!ready_rand || $random(seed) % 3 != 0);
    ucsdec_top dut_u (.CLK(clk), .RESETN(resetn), .OCT_VALID(oct_valid),
        .OCT_READY(oct_ready), .OCT_DATA(oct_data), .OCT_LAST(oct_last),
        .CHR_VALID(chr_valid), .CHR_READY(chr_ready), .CHR_UCS2(chr_ucs2),
        .CHR_CODE(chr_code), .BUSY(busy));
    ucsdec_card_model src_u (.clk(clk), .oct_ready(oct_ready), .oct_valid(oct_valid),
        .oct_data(oct_data), .oct_last(oct_last), .timed_out(timed_out));
    // ==========================================================
    // Reporting
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim;
        if (miscompares == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    // ==========================================================
    // Expected characters of one record; form picked once from the leading octet
    function automatic void model(input logic [7:0] r[$]);
        logic [15:0] base;
        int s;
        if (r[0] === FORM_PAIRS) begin
            // Pairs high then low, stop at all-ones pair or odd filler
            for (int i = 1; i + 1 < r.size(); i += 2) begin
                if ({r[i], r[i+1]} === 16'hFFFF)
                    break;
                exp_q.push_back({1'b1, r[i], r[i+1]});
            end
        end else if (r[0] === FORM_HALF || r[0] === FORM_FULL) begin
            base = (r[0] === FORM_HALF) ? {1'b0, r[2], 7'h00} : {r[2], r[3]};
            s = (r[0] === FORM_HALF) ? 3 : 4;
            // Exactly the counted octets; FF inside the count is a character
            for (int k = 0; k < int'(r[1]) && s + k < r.size(); k++)
                exp_q.push_back(r[s+k][7] ? {1'b1, base + {9'h000, r[s+k][6:0]}}
                    : {1'b0, 9'h000, r[s+k][6:0]});
        end else begin
            foreach (r[i])
                exp_q.push_back({1'b0, 8'h00, r[i]});
        end
    endfunction : model
    // ==========================================================
    // Stimulus helpers
    task automatic run_rec(input bit slow);
        model(rec);
        src_u.send(rec, slow);
        if (timed_out === 1'b1) begin
            miscompares++;
            end_sim();
        end
    endtask : run_rec
    task automatic run(input logic [95:0] bytes, input int len);
        rec.delete();
        for (int i = len - 1; i >= 0; i--)
            rec.push_back(bytes[8*i +: 8]);
        run_rec(1'b0);
    endtask : run
    task automatic run_random(input bit slow);
        int form;
        int n;
        rec.delete();
        form = $unsigned($random(seed)) % 4;
        n = $unsigned($random(seed)) % 8;
        rec.push_back(form == 3 ? 8'($random(seed)) & 8'h7F : FORM_PAIRS + 8'(form));
        if (form == 1 || form == 2)
            rec.push_back(8'(n));
        repeat (form == 2 ? 2 : (form == 1 ? 1 : 0)) rec.push_back(8'($random(seed)));
        repeat (form == 0 ? 2 * n : n) rec.push_back(8'($random(seed)) & (form == 3 ? 8'h7F : 8'hFF));
        rec.push_back(form == 3 ? 8'h41 : FILLER);
        run_rec(slow);
    endtask : run_random
    // Waits until every due character left, then the decoder must be idle
    task automatic drain;
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 2000) begin
            miscompares++;
            end_sim();
        end
        repeat (4) @(negedge clk);
        check({15'h0000, busy, chr_valid}, 17'h00000);
    endtask : drain
    // ==========================================================
    // Monitor: every taken character is compared with the next one due
    always @(posedge clk) begin
        if (resetn && chr_valid === 1'b1 && chr_ready === 1'b1) begin
            if (exp_q.size() == 0)
                check(17'h00000, 17'h1FFFF);
            else
                check({chr_ucs2, chr_code}, exp_q.pop_front());
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(negedge clk);
        check({14'h0000, chr_valid, busy, oct_ready}, 17'h00000);
        resetn = 1'b1;
        repeat (2) @(negedge clk);
        run(96'h80_0123_FFFF, 5);
        run(96'h81_0513_5395_A641_FFFF, 9);
        run(96'h82_0505_302D_82D3_2D31, 9);
        run(96'h80_1234_5678_FF, 6);
        run(96'h80_FFFF_1234, 5);
        run(96'h81_0020_4142, 5);
        run(96'h41_4243, 3);
        run(96'h82_02FF_FFFF_7F, 6);
        drain();
        // Receiver stalls: buffer fills and octets are refused, none lost
        ready_hold = 1'b1;
        fork
            run(96'h41_4243_4445_4647_4849_4A4B, 12);
            begin
                repeat (40) @(negedge clk);
                check({15'h0000, oct_ready, chr_valid}, 17'h00001);
                ready_hold = 1'b0;
            end
        join
        drain();
        ready_rand = 1'b1;
        repeat (60) run_random(1'($random(seed)));
        drain();
        end_sim();
    end
endmodule : ucsdec_top_test
